/* File: plcr_map.svh */
// register offsets, field positions, reset values and counts for the pll config bank
`ifndef PLCR_MAP_SVH
`define PLCR_MAP_SVH
`define PLCR_ADDR_W 5
`define PLCR_DATA_W 24
`define PLCR_OFS_LOCK 5'h07
`define PLCR_OFS_ANALOG 5'h08
`define PLCR_OFS_PUMP 5'h09
`define PLCR_RST_LOCK 24'h200844
`define PLCR_RST_ANALOG 24'h01bfff
`define PLCR_RST_PUMP 24'h547264
`define PLCR_LK_WIN_LSB 0
`define PLCR_LK_WIN_MSB 2
`define PLCR_LK_EN_BIT 11
`define PLCR_LK_TRAIN_BIT 20
`define PLCR_LK_SLIP_BIT 21
`define PLCR_AN_PIN_EN_BIT 5
`define PLCR_AN_BIAS_BIT 10
`define PLCR_AN_HFREF_BIT 21
`define PLCR_AN_LEVEL_BIT 22
`define PLCR_CP_DN_LSB 0
`define PLCR_CP_DN_MSB 6
`define PLCR_CP_UP_LSB 7
`define PLCR_CP_UP_MSB 13
`define PLCR_CP_OFS_LSB 14
`define PLCR_CP_OFS_MSB 20
`define PLCR_CP_OFS_UP_BIT 21
`define PLCR_CP_OFS_DN_BIT 22
`define PLCR_CP_HIGAIN_BIT 23
`define PLCR_CNT_W 17
`define PLCR_WIN_0 17'd5
`define PLCR_WIN_1 17'd32
`define PLCR_WIN_2 17'd96
`define PLCR_WIN_3 17'd256
`define PLCR_WIN_4 17'd512
`define PLCR_WIN_5 17'd2048
`define PLCR_WIN_6 17'd8192
`define PLCR_WIN_7 17'd65535
`define PLCR_CHIP_ADDR_W 3
`endif

/* File: plcr_pkg.sv */
// types shared by the pll config bank
`include "plcr_map.svh"
package plcr_pkg;
   typedef logic [`PLCR_DATA_W-1:0] plcr_word_t;
   typedef logic [`PLCR_ADDR_W-1:0] plcr_addr_t;
   typedef logic [`PLCR_CNT_W-1:0] plcr_cnt_t;
   typedef enum logic [1:0]
   {
      PLCR_LK_OFF = 2'b00,
      PLCR_LK_TRAIN = 2'b01,
      PLCR_LK_SEEK = 2'b10,
      PLCR_LK_HELD = 2'b11
   } plcr_lock_state_e;
endpackage

/* File: plcr_lock_detect.sv */
// lock detector: counts consecutive in-window compares to declare lock
`timescale 1ns/1ps
`include "plcr_map.svh"
module plcr_lock_detect
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic enable,
   input wire logic train_start,
   input wire logic [2:0] win_sel,
   input wire logic compare_valid,
   input wire logic compare_in_window,
   output logic lock_indicator,
   output logic training
);
   import plcr_pkg::*;

   plcr_lock_state_e state;
   plcr_lock_state_e next_state;
   plcr_cnt_t count;
   plcr_cnt_t next_count;
   logic next_lock;

   function automatic plcr_cnt_t win_target(input logic [2:0] sel);
      case (sel)
         3'h0: win_target = `PLCR_WIN_0;
         3'h1: win_target = `PLCR_WIN_1;
         3'h2: win_target = `PLCR_WIN_2;
         3'h3: win_target = `PLCR_WIN_3;
         3'h4: win_target = `PLCR_WIN_4;
         3'h5: win_target = `PLCR_WIN_5;
         3'h6: win_target = `PLCR_WIN_6;
         default: win_target = `PLCR_WIN_7;
      endcase
   endfunction

   always_comb
   begin
      next_state = state;
      next_count = count;
      next_lock = lock_indicator;
      case (state)
         PLCR_LK_OFF:
         begin
            next_lock = 1'b0;
            next_count = '0;
            if (enable)
               next_state = PLCR_LK_SEEK;
         end
         PLCR_LK_TRAIN:
         begin
            // training is a single settle cycle; it restarts the count
            next_lock = 1'b0;
            next_count = '0;
            next_state = PLCR_LK_SEEK;
         end
         PLCR_LK_SEEK:
         begin
            if (compare_valid)
            begin
               if (!compare_in_window)
                  next_count = '0;
               else if (count + 17'd1 >= win_target(win_sel))
               begin
                  next_lock = 1'b1;
                  next_state = PLCR_LK_HELD;
               end
               else
                  next_count = count + 17'd1;
            end
         end
         default:
         begin
            if (compare_valid && !compare_in_window)
            begin
               next_lock = 1'b0;
               next_count = '0;
               next_state = PLCR_LK_SEEK;
            end
         end
      endcase
      if (!enable)
      begin
         next_state = PLCR_LK_OFF;
         next_lock = 1'b0;
         next_count = '0;
      end
      else if (train_start)
      begin
         next_state = PLCR_LK_TRAIN;
         next_lock = 1'b0;
         next_count = '0;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= PLCR_LK_OFF;
         count <= '0;
         lock_indicator <= 1'b0;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
         lock_indicator <= next_lock;
      end
   end

   assign training = (state == PLCR_LK_TRAIN);
endmodule

/* File: plcr_config_bank.sv */
// lock detect, analog enable and charge pump configuration registers
// Contract
// - lock after 5..65535 consecutive in-window counts, set by 3-bit select
// - lock detect enable bit turns detection off or on; resets set
// - training starts only on a zero-to-one change of the training bit
// - slip guard adds about 6 mA pump gain for large phase error
// - cleared pin enable disables the shared lock/serial output pin
// - pin enable with pin-mode bit set drives the shared pin always
// - pin enable, pin-mode clear: release pin when chip address nonzero
// - bias enable bit switches external VCO buffer/prescaler bias
// - level select picks 1.8 V or 3 V supply level for pin
// - 7-bit down current, 20 uA per step, resets to 100
// - 7-bit up current, 20 uA per step, resets to 100
// - 7-bit offset magnitude, 5 uA per step, resets to 81
// - upward offset enable applies offset upward; resets cleared
// - downward offset enable applies offset downward; resets set
// - high-gain mode adds 3 mA pump current
// - registers reset to their documented defaults, reserved bits included
// - writes take effect on rising edge of serial load strobe
`timescale 1ns/1ps
`include "plcr_map.svh"
module plcr_config_bank
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic serial_load_strobe,
   input wire plcr_pkg::plcr_addr_t load_addr,
   input wire plcr_pkg::plcr_word_t load_data,
   input wire plcr_pkg::plcr_addr_t read_addr,
   output plcr_pkg::plcr_word_t read_data,
   input wire logic pin_always_drive,
   input wire logic [`PLCR_CHIP_ADDR_W-1:0] chip_addr,
   input wire logic serial_out_data,
   input wire logic compare_valid,
   input wire logic compare_in_window,
   input wire logic phase_error_large,
   output logic lock_indicator,
   output logic lock_training,
   output logic lock_serial_out_pin,
   output logic lock_serial_out_oe_n,
   output logic digital_3v_supply_level,
   output logic ext_vco_bias_enable,
   output logic high_freq_reference,
   output logic [6:0] pump_dn_code,
   output logic [6:0] pump_up_code,
   output logic [6:0] pump_offset_code,
   output logic pump_offset_up,
   output logic pump_offset_down,
   output logic high_gain_pump_mode,
   output logic cycle_slip_boost
);
   import plcr_pkg::*;

   plcr_word_t lock_detect_config;
   plcr_word_t analog_enable_config;
   plcr_word_t pump_current_config;
   plcr_word_t next_lock_detect_config;
   plcr_word_t next_analog_enable_config;
   plcr_word_t next_pump_current_config;
   logic strobe_q;
   logic next_strobe_q;
   logic load_edge;
   logic train_pulse;
   logic next_train_pulse;
   logic next_pin;
   logic next_oe_n;
   logic next_boost;
   logic pin_drive;

   // the serial strobe is taken as synchronous; its rising edge commits the
   // word, so a held-high strobe cannot write twice
   assign load_edge = serial_load_strobe && !strobe_q;

   always_comb
   begin
      next_strobe_q = serial_load_strobe;
      next_lock_detect_config = lock_detect_config;
      next_analog_enable_config = analog_enable_config;
      next_pump_current_config = pump_current_config;
      next_train_pulse = 1'b0;
      if (load_edge)
      begin
         // whole word is stored, reserved bits too, so they read back
         if (load_addr == `PLCR_OFS_LOCK)
         begin
            next_lock_detect_config = load_data;
            // only a zero-to-one change starts training
            next_train_pulse = load_data[`PLCR_LK_TRAIN_BIT]
               && !lock_detect_config[`PLCR_LK_TRAIN_BIT];
         end
         else if (load_addr == `PLCR_OFS_ANALOG)
            next_analog_enable_config = load_data;
         else if (load_addr == `PLCR_OFS_PUMP)
            next_pump_current_config = load_data;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         strobe_q <= 1'b0;
         lock_detect_config <= `PLCR_RST_LOCK;
         analog_enable_config <= `PLCR_RST_ANALOG;
         pump_current_config <= `PLCR_RST_PUMP;
         train_pulse <= 1'b0;
      end
      else
      begin
         strobe_q <= next_strobe_q;
         lock_detect_config <= next_lock_detect_config;
         analog_enable_config <= next_analog_enable_config;
         pump_current_config <= next_pump_current_config;
         train_pulse <= next_train_pulse;
      end
   end

   always_comb
   begin
      if (read_addr == `PLCR_OFS_LOCK)
         read_data = lock_detect_config;
      else if (read_addr == `PLCR_OFS_ANALOG)
         read_data = analog_enable_config;
      else if (read_addr == `PLCR_OFS_PUMP)
         read_data = pump_current_config;
      else
         read_data = '0;
   end

   plcr_lock_detect u_lock
   (
      .clk(clk),
      .rstn(rstn),
      .enable(lock_detect_config[`PLCR_LK_EN_BIT]),
      .train_start(train_pulse),
      .win_sel(lock_detect_config[`PLCR_LK_WIN_MSB:`PLCR_LK_WIN_LSB]),
      .compare_valid(compare_valid),
      .compare_in_window(compare_in_window),
      .lock_indicator(lock_indicator),
      .training(lock_training)
   );

   // shared pin: in bus-share mode only chip address zero may talk
   always_comb
   begin
      if (!analog_enable_config[`PLCR_AN_PIN_EN_BIT])
         pin_drive = 1'b0;
      else if (pin_always_drive)
         pin_drive = 1'b1;
      else
         pin_drive = (chip_addr == 3'h0);
      next_oe_n = !pin_drive;
      next_pin = pin_drive ? serial_out_data : 1'b0;
      // boost is registered: it follows the large-error flag one cycle later while the slip bit is set
      next_boost = lock_detect_config[`PLCR_LK_SLIP_BIT]
         && phase_error_large;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lock_serial_out_pin <= 1'b0;
         lock_serial_out_oe_n <= 1'b1;
         cycle_slip_boost <= 1'b0;
      end
      else
      begin
         lock_serial_out_pin <= next_pin;
         lock_serial_out_oe_n <= next_oe_n;
         cycle_slip_boost <= next_boost;
      end
   end

   // analog controls come straight from the stored fields
   assign digital_3v_supply_level =
      analog_enable_config[`PLCR_AN_LEVEL_BIT];
   assign ext_vco_bias_enable = analog_enable_config[`PLCR_AN_BIAS_BIT];
   assign high_freq_reference = analog_enable_config[`PLCR_AN_HFREF_BIT];
   assign pump_dn_code =
      pump_current_config[`PLCR_CP_DN_MSB:`PLCR_CP_DN_LSB];
   assign pump_up_code =
      pump_current_config[`PLCR_CP_UP_MSB:`PLCR_CP_UP_LSB];
   assign pump_offset_code =
      pump_current_config[`PLCR_CP_OFS_MSB:`PLCR_CP_OFS_LSB];
   assign pump_offset_up = pump_current_config[`PLCR_CP_OFS_UP_BIT];
   assign pump_offset_down = pump_current_config[`PLCR_CP_OFS_DN_BIT];
   assign high_gain_pump_mode =
      pump_current_config[`PLCR_CP_HIGAIN_BIT];
endmodule

/* File: plcr_config_bank_properties.sv */
// port assertions for the pll config bank
`timescale 1ns/1ps
module plcr_config_bank_properties
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic serial_load_strobe,
   input wire plcr_pkg::plcr_addr_t load_addr,
   input wire plcr_pkg::plcr_word_t load_data,
   input wire plcr_pkg::plcr_addr_t read_addr,
   input wire plcr_pkg::plcr_word_t read_data,
   input wire logic pin_always_drive,
   input wire logic [2:0] chip_addr,
   input wire logic compare_valid,
   input wire logic compare_in_window,
   input wire logic phase_error_large,
   input wire logic lock_indicator,
   input wire logic lock_training,
   input wire logic lock_serial_out_oe_n,
   input wire logic [6:0] pump_dn_code,
   input wire logic [6:0] pump_up_code,
   input wire logic [6:0] pump_offset_code,
   input wire logic pump_offset_up,
   input wire logic pump_offset_down,
   input wire logic high_gain_pump_mode,
   input wire logic ext_vco_bias_enable,
   input wire logic high_freq_reference,
   input wire logic digital_3v_supply_level,
   input wire logic cycle_slip_boost
);
   import plcr_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_load;
      !serial_load_strobe ##1 serial_load_strobe && load_addr == 5'h09;
   endsequence
   property p_load;
      s_load ##0 read_addr == 5'h09 |=> read_data == $past(load_data);
   endproperty
   a_load: assert property (p_load) else $error("pump load lost");
   property p_rst;
      $rose(rstn) |-> pump_dn_code == 7'h64 && pump_up_code == 7'h64
         && pump_offset_code == 7'h51 && !pump_offset_up && pump_offset_down
         && !high_gain_pump_mode && ext_vco_bias_enable;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset codes");
   property p_lock;
      $rose(lock_indicator) |-> $past(compare_valid && compare_in_window);
   endproperty
   a_lock: assert property (p_lock) else $error("lock w/o hit");
   property p_miss;
      compare_valid && !compare_in_window |=> !lock_indicator;
   endproperty
   a_miss: assert property (p_miss) else $error("lock after miss");
   property p_train;
      lock_training |-> !lock_indicator ##1 !lock_training;
   endproperty
   a_train: assert property (p_train) else $error("training pulse");
   property p_shared;
      !pin_always_drive && chip_addr != 3'h0 |=> lock_serial_out_oe_n;
   endproperty
   a_shared: assert property (p_shared) else $error("pin not freed");
   property p_drive;
      read_addr == 5'h08 && read_data[5] && pin_always_drive
         |=> !lock_serial_out_oe_n;
   endproperty
   a_drive: assert property (p_drive) else $error("pin not driven");
   property p_off;
      read_addr == 5'h08 && !read_data[5] |=> lock_serial_out_oe_n;
   endproperty
   a_off: assert property (p_off) else $error("pin not off");
   property p_slip;
      read_addr == 5'h07
         |=> cycle_slip_boost == $past(phase_error_large && read_data[21]);
   endproperty
   a_slip: assert property (p_slip) else $error("slip boost");
   property p_pump;
      read_addr == 5'h09 |-> read_data == {high_gain_pump_mode,
         pump_offset_down, pump_offset_up, pump_offset_code, pump_up_code,
         pump_dn_code};
   endproperty
   a_pump: assert property (p_pump)
      else $error("pump fields");
   property p_analog;
      read_addr == 5'h08 |-> {read_data[22:21], read_data[10]} ==
         {digital_3v_supply_level, high_freq_reference, ext_vco_bias_enable};
   endproperty
   a_analog: assert property (p_analog)
      else $error("analog fields");
endmodule
bind plcr_config_bank plcr_config_bank_properties u_props (.*);

/* File: plcr_host_model.sv */
// serial host model issuing register loads
`timescale 1ns/1ps
module plcr_host_model
(
   input wire logic clk,
   output plcr_pkg::plcr_addr_t load_addr,
   output plcr_pkg::plcr_word_t load_data,
   output logic serial_load_strobe
);
   import plcr_pkg::*;
   initial
   begin
      serial_load_strobe = 1'b0;
      load_addr = 5'h1f;
      load_data = 24'h0;
   end
   // released lines show the inverse so stale data is never trusted
   task automatic load(input plcr_addr_t a, input plcr_word_t d);
      @(posedge clk) serial_load_strobe <= 1'b1;
      load_addr <= a;
      load_data <= d;
      @(posedge clk) serial_load_strobe <= 1'b0;
      load_addr <= ~a;
      load_data <= ~d;
      @(posedge clk);
   endtask
   task automatic retrain(input plcr_word_t w);
      load(5'h07, w & ~24'h100000);
      load(5'h07, w | 24'h100000);
   endtask
endmodule

/* File: plcr_config_bank_tb_top.sv */
// testbench for the pll config bank
`timescale 1ns/1ps
module plcr_config_bank_tb_top;
   import plcr_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, pin_always_drive = 1'b0;
   logic serial_out_data = 1'b1, compare_valid = 1'b0;
   logic compare_in_window = 1'b0, phase_error_large = 1'b0;
   logic serial_load_strobe, lock_indicator, lock_training;
   logic lock_serial_out_pin, lock_serial_out_oe_n, pump_offset_up;
   logic digital_3v_supply_level, ext_vco_bias_enable, cycle_slip_boost;
   logic high_freq_reference, pump_offset_down, high_gain_pump_mode;
   logic [6:0] pump_dn_code, pump_up_code, pump_offset_code;
   logic [2:0] chip_addr = 3'h0;
   plcr_addr_t load_addr, read_addr = 5'h07;
   plcr_word_t load_data, read_data;
   int n_errors = 0;
   int checks = 0;
   plcr_config_bank DUT (.*);
   plcr_host_model host (.*);
   always #5 clk = ~clk;
   task automatic chk(input plcr_word_t got, input plcr_word_t exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rd(input plcr_addr_t a, input plcr_word_t exp);
      @(posedge clk) read_addr <= a;
      @(negedge clk) chk(read_data, exp);
   endtask
   // gaps in valid are not compares, so they keep the run going
   task automatic cmp(input int n, input logic w);
      repeat (n)
      begin
         @(posedge clk) compare_valid <= 1'b1;
         compare_in_window <= w;
      end
      @(posedge clk) compare_valid <= 1'b0;
      @(negedge clk);
   endtask
   task automatic watch(output logic seen);
      seen = 1'b0;
      repeat (8)
         @(negedge clk) seen |= lock_training;
   endtask
   task automatic pin(input logic a, input logic [2:0] c, input logic [1:0] e);
      @(posedge clk) pin_always_drive <= a;
      chip_addr <= c;
      repeat (2)
         @(posedge clk);
      @(negedge clk) chk({lock_serial_out_oe_n, lock_serial_out_pin}, e);
   endtask
   task automatic t_regs;
      plcr_word_t v[3] = '{24'hbfffff, 24'h400000, 24'h547264};
      rd(5'h07, 24'h200844);
      rd(5'h08, 24'h01bfff);
      rd(5'h09, 24'h547264);
      foreach (v[i])
      begin
         host.load(5'h09, v[i]);
         rd(5'h09, v[i]);
      end
      host.load(5'h08, 24'h61bbff);
      rd(5'h08, 24'h61bbff);
      host.load(5'h0a, 24'h123456);
      rd(5'h0a, 24'h0);
      rd(5'h08, 24'h61bbff);
      $display("t_regs done");
   endtask
   task automatic t_lock;
      int w[8] = '{5, 32, 96, 256, 512, 2048, 8192, 65535};
      for (int s = 0; s < 8; s++)
      begin
         host.load(5'h07, 24'h200840 | 24'(s));
         cmp(w[s] - 1, 1'b1);
         chk(lock_indicator, 1'b0);
         cmp(1, 1'b1);
         chk(lock_indicator, 1'b1);
         cmp(1, 1'b0);
         chk(lock_indicator, 1'b0);
      end
      $display("t_lock done");
   endtask
   task automatic t_train;
      logic seen;
      host.load(5'h07, 24'h200840);
      cmp(5, 1'b1);
      host.retrain(24'h200840);
      watch(seen);
      chk(seen, 1'b1);
      chk(lock_indicator, 1'b0);
      host.load(5'h07, 24'h300840);
      watch(seen);
      chk(seen, 1'b0);
      host.load(5'h07, 24'h300040);
      cmp(5, 1'b1);
      chk(lock_indicator, 1'b0);
      $display("t_train done");
   endtask
   task automatic t_pin_slip;
      rd(5'h08, 24'h61bbff);
      pin(1'b0, 3'h0, 2'b01);
      pin(1'b0, 3'h1, 2'b10);
      pin(1'b1, 3'h5, 2'b01);
      // a low data bit proves the pin carries the data, not a fixed one
      @(posedge clk) serial_out_data <= 1'b0;
      pin(1'b1, 3'h5, 2'b00);
      @(posedge clk) serial_out_data <= 1'b1;
      host.load(5'h08, 24'h61bbdf);
      pin(1'b1, 3'h5, 2'b10);
      rd(5'h07, 24'h300040);
      @(posedge clk) phase_error_large <= 1'b1;
      @(posedge clk);
      @(negedge clk) chk(cycle_slip_boost, 1'b1);
      host.load(5'h07, 24'h100040);
      @(negedge clk) chk(cycle_slip_boost, 1'b0);
      $display("t_pin_slip done");
   endtask
   task automatic complete_run;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3)
         @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_lock();
      t_train();
      t_pin_slip();
      complete_run();
   end
endmodule
